//--- sleep_power_ctrl.v
/*
  Sleep mode and power-management controller: sleep entry, clock domain
  gating, wake qualification, start-up timing, brown-out sleep disable
  and per-peripheral clock gating.
  Assumes a core that pulses sleep_instr_i, wake sources that are
  synchronous levels, and an 8-bit register port with read data one
  cycle after the read strobe.
*/
`timescale 1ns/100ps
`include "pm_map.vh"

module sleep_power_ctrl #(
  parameter SLEEP_START_CYC = `PM_SLEEP_START_CYC,
  parameter RESET_START_CYC = `PM_RESET_START_CYC,
  parameter CNT_W = 16
) (
  input wire sys_clk_i,            // system clock, 20 MHz
  input wire rst_n_i,              // synchronous reset, active low
  input wire [7:0] addr_i,         // register address
  input wire [7:0] wr_data_i,      // register write data
  input wire wr_i,                 // write strobe
  input wire rd_i,                 // read strobe
  output reg [7:0] rd_data_o,      // read data, cycle after strobe
  input wire sleep_instr_i,        // core executes the sleep instruction
  input wire irq_any_i,            // any enabled interrupt pending
  input wire conv_done_irq_i,      // converter conversion complete
  input wire spm_ready_irq_i,      // store program / eeprom ready
  input wire ext_int_zero_lvl_i,   // level interrupt on ext int zero
  input wire pin_change_irq_i,     // pin change interrupt
  input wire serial_start_irq_i,   // serial start condition interrupt
  input wire wdt_irq_i,            // watchdog interrupt
  input wire reset_req_i,          // external, watchdog or brown-out reset
  input wire conv_enabled_i,       // converter enabled by software
  input wire bod_fuse_en_i,        // brown-out detector enabled by fuses
  output reg cpu_clk_en_o,         // cpu_clock enable
  output reg flash_clk_en_o,       // flash_clock enable
  output reg io_clk_en_o,          // io_clock enable
  output reg conv_clk_en_o,        // converter_clock enable
  output reg fast_clk_en_o,        // fast_peripheral_clock enable
  output reg osc_en_o,             // main oscillator enable
  output reg timer1_clk_en_o,      // timer one clock enable
  output reg timer0_clk_en_o,      // timer zero clock enable
  output reg serial_clk_en_o,      // serial interface clock enable
  output reg conv_periph_en_o,     // converter block clock enable
  output reg [3:0] periph_block_o, // peripheral register access blocked
  output reg input_buf_en_o,       // digital input buffers enabled
  output reg bod_en_o,             // brown-out detector enabled
  output reg conv_start_o,         // converter start pulse
  output reg wake_resume_o,        // pulse: run handler, resume after sleep
  output reg wake_restart_o,       // pulse: restart from reset vector
  output reg sleeping_o            // controller not in active state
);

  ////////////////////////////////////////////////////////////////////
  // state and register declarations

  localparam [3:0] ST_ACTIVE = 4'h1; // core running
  localparam [3:0] ST_SLEEP = 4'h2;  // in a sleep mode
  localparam [3:0] ST_START = 4'h4;  // oscillator start-up wait
  localparam [3:0] ST_HALT = 4'h8;   // four-cycle core halt
  localparam [7:0] CTRL_RST = `PM_CTRL_RST; // control byte reset image

  reg [3:0] state;               // controller state
  reg [3:0] next_state;          // next controller state
  reg sleep_enable_bit;          // software sleep enable
  reg [1:0] sleep_mode_field;    // software mode select
  reg [3:0] peripheral_clock_gate_register; // per-peripheral gates
  reg [1:0] mode_q;              // mode latched at sleep entry
  reg [2:0] unlock_cnt;          // unlock window remaining
  reg [2:0] off_cnt;             // detector-off bit timer
  reg [2:0] halt_cnt;            // halt cycles remaining
  reg bod_off_q;                 // detector switched off for this sleep
  reg [5:0] next_dom;            // next domain enables
  reg start_load;                // load start-up counter
  reg [CNT_W-1:0] start_value;   // start-up count to load

  wire ctrl_wr;                  // write to core control
  wire gate_wr;                  // write to peripheral gate
  wire unlock_open;              // unlock window is open
  wire brownout_sleep_off;       // detector-off bit is active
  wire sleep_go;                 // valid sleep entry this cycle
  wire wake_irq;                 // qualified interrupt wake
  wire start_done;               // start-up delay finished

  ////////////////////////////////////////////////////////////////////
  // functions

  // domain enables {cpu,flash,io,conv,fast,osc} for a sleep mode
  function [5:0] mode_clocks;
    input [1:0] mode;
    begin
      case (mode)
        // idle clock set
        `PM_MODE_IDLE: mode_clocks = 6'h0F;
        // noise reduction clock set
        `PM_MODE_NOISE: mode_clocks = 6'h05;
        // power-down clock set
        `PM_MODE_DOWN: mode_clocks = 6'h00;
        // reserved code stops nothing
        default: mode_clocks = 6'h3F;
      endcase
    end
  endfunction

  // wake qualification per sleep mode
  function wake_ok;
    input [1:0] mode;
    input [6:0] src; // {any,done,spm,lvl,pin,start,wdt}
    begin
      case (mode)
        `PM_MODE_IDLE: wake_ok = src[6];
        `PM_MODE_NOISE: wake_ok = src[5] | src[4] | src[3] | src[2];
        `PM_MODE_DOWN: wake_ok = src[1] | src[3] | src[2];
        default: wake_ok = 1'b0;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // decode

  assign ctrl_wr = wr_i && (addr_i == `PM_ADDR_CTRL);
  assign gate_wr = wr_i && (addr_i == `PM_ADDR_GATE);
  assign unlock_open = (unlock_cnt != 3'h0);
  assign brownout_sleep_off = (off_cnt != 3'h0) && (off_cnt <= `PM_BOD_OFF_ACT);
  assign sleep_go = sleep_instr_i && sleep_enable_bit &&
                    (sleep_mode_field != `PM_MODE_RSVD);
  assign wake_irq = wake_ok(mode_q, {irq_any_i, conv_done_irq_i,
                    spm_ready_irq_i, ext_int_zero_lvl_i, pin_change_irq_i,
                    serial_start_irq_i, wdt_irq_i});

  ////////////////////////////////////////////////////////////////////
  // software registers

  // mode select, enable bit and peripheral gates
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      sleep_enable_bit <= CTRL_RST[`PM_BIT_SLEEP_EN];
      sleep_mode_field <= CTRL_RST[`PM_BIT_MODE_HI:`PM_BIT_MODE_LO];
      peripheral_clock_gate_register <= `PM_GATE_RST;
    end else begin
      if (ctrl_wr) begin
        sleep_enable_bit <= wr_data_i[`PM_BIT_SLEEP_EN];
        sleep_mode_field <= wr_data_i[`PM_BIT_MODE_HI:`PM_BIT_MODE_LO];
      end
      if (gate_wr) begin
        peripheral_clock_gate_register <= wr_data_i[3:0];
      end
    end
  end

  // timed unlock of the detector-off bit
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      unlock_cnt <= 3'h0;
      off_cnt <= 3'h0;
    end else begin
      // off bit runs its delay, then its active window
      if (off_cnt != 3'h0) begin
        off_cnt <= off_cnt - 3'h1;
      end
      if (ctrl_wr && wr_data_i[`PM_BIT_BOD_OFF] && wr_data_i[`PM_BIT_UNLOCK]) begin
        // rewriting inside the window neither extends nor restarts it
        if (!unlock_open) begin
          unlock_cnt <= `PM_UNLOCK_CYC;
        end else begin
          unlock_cnt <= unlock_cnt - 3'h1;
        end
      end else if (ctrl_wr && wr_data_i[`PM_BIT_BOD_OFF] && unlock_open) begin
        unlock_cnt <= 3'h0;
        off_cnt <= `PM_BOD_OFF_DLY + `PM_BOD_OFF_ACT;
      end else if (unlock_open) begin
        unlock_cnt <= unlock_cnt - 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // start-up delay counter

  wake_delay_counter #(
    .W(CNT_W)
  ) u_start (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .load_i(start_load),
    .value_i(start_value),
    .done_o(start_done)
  );

  ////////////////////////////////////////////////////////////////////
  // sleep state machine, next state

  always @* begin
    next_state = state;
    start_load = 1'b0;
    if (bod_off_q) begin
      start_value = RESET_START_CYC[CNT_W-1:0];
    end else begin
      start_value = SLEEP_START_CYC[CNT_W-1:0];
    end
    case (state)
      ST_ACTIVE: begin
        if (sleep_go) begin
          next_state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (reset_req_i) begin
          next_state = ST_ACTIVE;
        end else if (wake_irq && (mode_q == `PM_MODE_DOWN || bod_off_q)) begin
          next_state = ST_START;
          start_load = 1'b1;
        end else if (wake_irq) begin
          next_state = ST_HALT;
        end
      end
      ST_START: begin
        if (reset_req_i) begin
          next_state = ST_ACTIVE;
        end else if (start_done) begin
          next_state = ST_HALT;
        end
      end
      ST_HALT: begin
        if (reset_req_i) begin
          next_state = ST_ACTIVE;
        end else if (halt_cnt == 3'h1) begin
          next_state = ST_ACTIVE;
        end
      end
      default: begin
        next_state = ST_ACTIVE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // sleep state machine, registers

  // state, latched mode, halt count and detector-off flag
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state <= ST_ACTIVE;
      mode_q <= `PM_MODE_IDLE;
      halt_cnt <= 3'h0;
      bod_off_q <= 1'b0;
    end else begin
      state <= next_state;
      if (state == ST_ACTIVE && sleep_go) begin
        mode_q <= sleep_mode_field;
        bod_off_q <= brownout_sleep_off && (sleep_mode_field == `PM_MODE_DOWN);
      end else if (next_state == ST_ACTIVE || next_state == ST_HALT) begin
        bod_off_q <= 1'b0;
      end
      if (next_state == ST_HALT && state != ST_HALT) begin
        halt_cnt <= `PM_HALT_CYC;
      end else if (halt_cnt != 3'h0) begin
        halt_cnt <= halt_cnt - 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // clock domain enables

  // domain set for the next state
  always @* begin
    case (next_state)
      ST_ACTIVE: next_dom = 6'h3F;
      ST_SLEEP: next_dom = (state == ST_ACTIVE) ? mode_clocks(sleep_mode_field)
                                                 : mode_clocks(mode_q);
      // oscillator only while it settles
      ST_START: next_dom = 6'h01;
      // cpu and flash clocks halted, the rest runs
      ST_HALT: next_dom = 6'h0F;
      default: next_dom = 6'h3F;
    endcase
  end

  // gating only, nothing cleared
  // registered clock enables and peripheral gates
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cpu_clk_en_o <= 1'b1;
      flash_clk_en_o <= 1'b1;
      io_clk_en_o <= 1'b1;
      conv_clk_en_o <= 1'b1;
      fast_clk_en_o <= 1'b1;
      osc_en_o <= 1'b1;
      timer1_clk_en_o <= 1'b1;
      timer0_clk_en_o <= 1'b1;
      serial_clk_en_o <= 1'b1;
      conv_periph_en_o <= 1'b1;
      periph_block_o <= 4'h0;
      input_buf_en_o <= 1'b1;
    end else begin
      cpu_clk_en_o <= next_dom[5];
      flash_clk_en_o <= next_dom[4];
      io_clk_en_o <= next_dom[3];
      conv_clk_en_o <= next_dom[2];
      fast_clk_en_o <= next_dom[1];
      osc_en_o <= next_dom[0];
      timer1_clk_en_o <= next_dom[1] &
                         ~peripheral_clock_gate_register[`PM_BIT_TIMER1];
      timer0_clk_en_o <= next_dom[3] &
                         ~peripheral_clock_gate_register[`PM_BIT_TIMER0];
      serial_clk_en_o <= next_dom[3] &
                         ~peripheral_clock_gate_register[`PM_BIT_SERIAL];
      conv_periph_en_o <= next_dom[2] &
                          ~peripheral_clock_gate_register[`PM_BIT_CONV];
      periph_block_o <= peripheral_clock_gate_register;
      input_buf_en_o <= next_dom[3] | next_dom[2];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // detector, converter start and wake pulses

  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      bod_en_o <= 1'b0;
      conv_start_o <= 1'b0;
      wake_resume_o <= 1'b0;
      wake_restart_o <= 1'b0;
      sleeping_o <= 1'b0;
    end else begin
      bod_en_o <= bod_fuse_en_i & ~bod_off_q;
      conv_start_o <= (state == ST_ACTIVE) && sleep_go && conv_enabled_i &&
                      (sleep_mode_field != `PM_MODE_DOWN);
      wake_resume_o <= (state == ST_HALT) && !reset_req_i && (halt_cnt == 3'h1);
      wake_restart_o <= (state != ST_ACTIVE) && reset_req_i;
      sleeping_o <= (next_state != ST_ACTIVE);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // register read port

  // read data stand the cycle after the strobe
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rd_data_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        // core control with live off bit and window
        `PM_ADDR_CTRL: rd_data_o <= {brownout_sleep_off, 1'b0, sleep_enable_bit,
                                     sleep_mode_field, unlock_open, 2'h0};
        `PM_ADDR_GATE: rd_data_o <= {4'h0, peripheral_clock_gate_register};
        // controller state
        `PM_ADDR_STAT: rd_data_o <= {1'b0, bod_off_q, brownout_sleep_off,
                                     unlock_open, state};
        // unmapped reads zero
        default: rd_data_o <= 8'h00;
      endcase
    end else begin
      rd_data_o <= 8'h00;
    end
  end

endmodule // sleep_power_ctrl

//--- pm_map.vh
/*
  Address map, field positions, reset values, mode codes and cycle counts
  for the sleep and power-management controller.
  Assumes an 8-bit register port and one system clock.
*/
`ifndef PM_MAP_VH
`define PM_MAP_VH

// register addresses
`define PM_ADDR_GATE 8'h20
`define PM_ADDR_CTRL 8'h21
`define PM_ADDR_STAT 8'h22

// core control field positions
`define PM_BIT_BOD_OFF 7
`define PM_BIT_SLEEP_EN 5
`define PM_BIT_MODE_HI 4
`define PM_BIT_MODE_LO 3
`define PM_BIT_UNLOCK 2

// peripheral gate field positions
`define PM_BIT_TIMER1 3
`define PM_BIT_TIMER0 2
`define PM_BIT_SERIAL 1
`define PM_BIT_CONV 0

// reset values
`define PM_CTRL_RST 8'h00
`define PM_GATE_RST 4'h0

// sleep mode codes
`define PM_MODE_IDLE 2'h0
`define PM_MODE_NOISE 2'h1
`define PM_MODE_DOWN 2'h2
`define PM_MODE_RSVD 2'h3

// cycle counts
`define PM_UNLOCK_CYC 3'h4
`define PM_BOD_OFF_DLY 3'h3
`define PM_BOD_OFF_ACT 3'h3
`define PM_HALT_CYC 3'h4
`define PM_SLEEP_START_CYC 16
`define PM_RESET_START_CYC 64

`endif

//--- wake_delay_counter.v
/*
  Down counter that times the oscillator start-up delay on wake.
  Assumes load_i is a one-cycle pulse and value_i is at least one.
*/
`timescale 1ns/100ps

module wake_delay_counter #(
  parameter W = 16
) (
  input wire sys_clk_i,         // system clock
  input wire rst_n_i,           // synchronous reset, active low
  input wire load_i,            // load pulse
  input wire [W-1:0] value_i,   // cycles to count
  output wire done_o            // count has run out
);

  reg [W-1:0] count; // remaining cycles

  // load or count down to zero
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      count <= {W{1'b0}};
    end else if (load_i) begin
      count <= value_i;
    end else if (count != {W{1'b0}}) begin
      count <= count - {{(W-1){1'b0}}, 1'b1};
    end
  end

  assign done_o = (count == {W{1'b0}});

endmodule // wake_delay_counter

//--- sleep_power_monitor.sv
/*
  Port checker for the sleep and power-management controller.
  Assumes binding to sleep_power_ctrl and a control byte at 0x21.
*/
`timescale 1ns/100ps
module sleep_power_monitor (
  input wire sys_clk_i,        // clock
  input wire rst_n_i,          // reset, low
  input wire [7:0] addr_i,     // address
  input wire [7:0] wr_data_i,  // write data
  input wire wr_i,             // write strobe
  input wire rd_i,             // read strobe
  input wire [7:0] rd_data_o,  // read data
  input wire sleep_instr_i,    // sleep pulse
  input wire reset_req_i,      // reset request
  input wire conv_enabled_i,   // converter on
  input wire bod_fuse_en_i,    // detector fuse
  input wire cpu_clk_en_o,     // cpu clock
  input wire flash_clk_en_o,   // flash clock
  input wire io_clk_en_o,      // io clock
  input wire conv_clk_en_o,    // converter clock
  input wire fast_clk_en_o,    // fast clock
  input wire osc_en_o,         // oscillator
  input wire input_buf_en_o,   // input buffers
  input wire bod_en_o,         // detector on
  input wire conv_start_o,     // start pulse
  input wire wake_resume_o,    // resume pulse
  input wire wake_restart_o,   // restart pulse
  input wire sleeping_o        // not active
);
  ////////////////////////////////////////////////////////////////////////////////
  reg [2:0] ctl; // shadow of enable and mode bits
  // shadow follows control byte writes
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) ctl <= 3'h0;
    else if (wr_i && addr_i == 8'h21) ctl <= wr_data_i[5:3];
  end
  wire go = sleep_instr_i && !sleeping_o && ctl[2] && !reset_req_i; // sleep taken
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_idle;
    !cpu_clk_en_o && !flash_clk_en_o && io_clk_en_o && conv_clk_en_o && fast_clk_en_o && osc_en_o;
  endsequence
  sequence s_noise;
    !cpu_clk_en_o && !flash_clk_en_o && !io_clk_en_o && conv_clk_en_o && osc_en_o;
  endsequence
  sequence s_restart;
    wake_restart_o && !sleeping_o && cpu_clk_en_o && osc_en_o;
  endsequence
  AST_IDLE_GATES: assert property (go && ctl[1:0] == 2'h0 |-> ##2 s_idle)
    else $error("idle clock pattern wrong");
  AST_NOISE_GATES: assert property (go && ctl[1:0] == 2'h1 |-> ##2 s_noise)
    else $error("noise clock pattern wrong");
  AST_OSC_OFF_ALL: assert property (!osc_en_o |-> !(cpu_clk_en_o || io_clk_en_o || conv_clk_en_o || fast_clk_en_o || flash_clk_en_o))
    else $error("clock runs with oscillator off");
  AST_NO_SLEEP: assert property (sleep_instr_i && !sleeping_o && (!ctl[2] || ctl[1:0] == 2'h3) |=> !sleeping_o && cpu_clk_en_o)
    else $error("sleep taken while refused");
  AST_BUF_OFF: assert property (!io_clk_en_o && !conv_clk_en_o |-> !input_buf_en_o)
    else $error("input buffers left on");
  AST_RESTART: assert property (reset_req_i && sleeping_o |=> s_restart)
    else $error("reset in sleep not restarting");
  AST_RESUME: assert property (wake_resume_o |-> $past(sleeping_o) && !sleeping_o && cpu_clk_en_o)
    else $error("resume without halt end");
  AST_CONV_START: assert property (go && !ctl[1] && conv_enabled_i |-> ##[1:2] conv_start_o)
    else $error("no conversion start");
  AST_BOD_ACTIVE: assert property (!sleeping_o && !$past(sleeping_o) && $past(rst_n_i) |-> bod_en_o == $past(bod_fuse_en_i))
    else $error("detector off while active");
  AST_RD_IDLE: assert property (!$past(rd_i) |-> rd_data_o == 8'h00)
    else $error("read data outside answer cycle");
  AST_GATE_HI: assert property ($past(rd_i) && $past(addr_i) == 8'h20 |-> rd_data_o[7:4] == 4'h0)
    else $error("gate upper bits not zero");
endmodule // sleep_power_monitor
bind sleep_power_ctrl sleep_power_monitor u_mon (.*);

//--- wake_source_model.sv
/*
  Wake source model: raises one source level on command and holds it.
  Assumes the bench pulses fire_i with sel_i and drop_i to lower levels.
*/
`timescale 1ns/100ps
module wake_source_model (
  input wire sys_clk_i,   // clock
  input wire rst_n_i,     // reset, low
  input wire fire_i,      // raise source
  input wire [2:0] sel_i, // source index
  input wire drop_i,      // lower all
  input wire wake_i,      // device woke
  output reg [7:0] src_o  // source levels
);
  // levels are held until drop_i or the device reports a wake
  always @(posedge sys_clk_i) begin
    if (!rst_n_i || drop_i || wake_i) src_o <= 8'h00;
    else if (fire_i) src_o[sel_i] <= 1'b1;
  end
endmodule // wake_source_model

//--- sleep_mode_power_controller_bench.sv
/*
  Self-checking bench for the sleep and power-management controller.
  Assumes short start-up counts set through the parameters.
*/
`timescale 1ns/100ps
module sleep_mode_power_controller_bench;
  localparam NS = 4;  // short start-up count
  localparam RS = 20; // reset start-up count
  reg sys_clk_i = 1'b0, rst_n_i = 1'b0, wr = 1'b0, rd = 1'b0, slp = 1'b0;
  reg conv_en = 1'b0, fire = 1'b0, drop = 1'b0;
  reg [7:0] addr = 8'h00, wdat = 8'h00;
  reg [2:0] sel = 3'h0;
  wire [7:0] src, rd_data_o;
  wire [3:0] blk;
  wire cpu, fl, io, cv, fs, osc, t1, t0, ser, cvp, ibuf, bod, cst, wake_resume_o, wake_restart_o;
  wire sleeping_o;
  integer n_fail = 0, samples_checked = 0, n_start = 0, n;
  always #25 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) if (cst === 1'b1) n_start <= n_start + 1;
  sleep_power_ctrl #(.SLEEP_START_CYC(NS), .RESET_START_CYC(RS)) dut_u (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .addr_i(addr), .wr_data_i(wdat),
    .wr_i(wr), .rd_i(rd), .rd_data_o(rd_data_o), .sleep_instr_i(slp),
    .irq_any_i(src[0]), .conv_done_irq_i(src[1]), .spm_ready_irq_i(src[2]),
    .ext_int_zero_lvl_i(src[3]), .pin_change_irq_i(src[4]), .serial_start_irq_i(src[5]),
    .wdt_irq_i(src[6]), .reset_req_i(src[7]), .conv_enabled_i(conv_en),
    .bod_fuse_en_i(1'b1), .cpu_clk_en_o(cpu), .flash_clk_en_o(fl), .io_clk_en_o(io),
    .conv_clk_en_o(cv), .fast_clk_en_o(fs), .osc_en_o(osc), .timer1_clk_en_o(t1),
    .timer0_clk_en_o(t0), .serial_clk_en_o(ser), .conv_periph_en_o(cvp),
    .periph_block_o(blk), .input_buf_en_o(ibuf), .bod_en_o(bod), .conv_start_o(cst),
    .wake_resume_o(wake_resume_o), .wake_restart_o(wake_restart_o), .sleeping_o(sleeping_o));
  wake_source_model part_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .fire_i(fire),
    .sel_i(sel), .drop_i(drop), .wake_i(wake_resume_o | wake_restart_o), .src_o(src));
  ////////////////////////////////////////////////////////////////////////////////
  task test_done;
    $display("checks %0d fails %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task wreg(input [7:0] a, input [7:0] d);
    @(posedge sys_clk_i) begin addr <= a; wdat <= d; wr <= 1'b1; end
    @(posedge sys_clk_i) wr <= 1'b0;
  endtask
  task rreg(input [7:0] a, input [7:0] e);
    @(posedge sys_clk_i) begin addr <= a; rd <= 1'b1; end
    @(posedge sys_clk_i) rd <= 1'b0;
    #1 chk(rd_data_o, e);
  endtask
  task do_sleep;
    @(posedge sys_clk_i) slp <= 1'b1;
    @(posedge sys_clk_i) slp <= 1'b0;
    @(posedge sys_clk_i) #1;
  endtask
  task pulse_src(input [2:0] s, input d);
    @(posedge sys_clk_i) begin fire <= !d; drop <= d; sel <= s; end
    @(posedge sys_clk_i) begin fire <= 1'b0; drop <= 1'b0; end
  endtask
  task wait_wake;
    n = 0;
    do begin @(posedge sys_clk_i); #1 n = n + 1; end
    while (wake_resume_o !== 1'b1 && wake_restart_o !== 1'b1 && n < 300);
    if (n >= 300) begin
      n_fail = n_fail + 1;
      $display("BAD %0t no wake", $time);
      test_done;
    end
  endtask
  task stay_asleep;
    repeat (8) @(posedge sys_clk_i);
    #1 chk(sleeping_o, 1);
    pulse_src(0, 1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_reset;
    chk({cpu, fl, io, cv, fs, osc, ibuf, sleeping_o}, 8'hFE);
    rreg(8'h21, 8'h00);
    chk(bod, 1);
    $display("test reset done");
  endtask
  task t_gate;
    wreg(8'h20, 8'hFF);
    rreg(8'h20, 8'h0F);
    chk({blk, t1, t0, ser, cvp}, 8'hF0);
    wreg(8'h20, 8'h00);
    rreg(8'h20, 8'h00);
    chk({blk, t1, t0, ser, cvp}, 8'h0F);
    rreg(8'h40, 8'h00);
    $display("test gate done");
  endtask
  task t_idle;
    @(posedge sys_clk_i) conv_en <= 1'b1;
    wreg(8'h20, 8'h05);
    wreg(8'h21, 8'h20);
    n = n_start;
    do_sleep;
    chk({cpu, fl, io, cv, fs, osc}, 8'h0F);
    chk(n_start - n, 1);
    pulse_src(0, 0);
    wait_wake;
    chk(n, 5);
    rreg(8'h20, 8'h05);
    $display("test idle done");
  endtask
  task t_noise;
    wreg(8'h21, 8'h28);
    n = n_start;
    do_sleep;
    chk({cpu, fl, io, cv, fs, osc}, 8'h05);
    chk(n_start - n, 1);
    pulse_src(6, 0);
    stay_asleep;
    pulse_src(4, 0);
    wait_wake;
    chk(sleeping_o, 0);
    $display("test noise done");
  endtask
  task t_down;
    @(posedge sys_clk_i) conv_en <= 1'b0;
    wreg(8'h21, 8'h30);
    do_sleep;
    chk({cpu, fl, io, cv, fs, osc, ibuf}, 8'h00);
    pulse_src(1, 0);
    stay_asleep;
    pulse_src(5, 0);
    wait_wake;
    chk(n >= NS + 5 && n <= NS + 9, 1);
    $display("test down done");
  endtask
  task t_refuse;
    wreg(8'h21, 8'h38);
    do_sleep;
    chk({sleeping_o, cpu}, 8'h01);
    wreg(8'h21, 8'h10);
    do_sleep;
    chk({sleeping_o, cpu}, 8'h01);
    $display("test refuse done");
  endtask
  task t_bod;
    wreg(8'h21, 8'hB0);
    do_sleep;
    chk(bod, 1);
    pulse_src(3, 0);
    wait_wake;
    wreg(8'h21, 8'h84);
    rreg(8'h21, 8'h04);
    wreg(8'h21, 8'hB0);
    repeat (3) @(posedge sys_clk_i);
    do_sleep;
    chk(bod, 0);
    rreg(8'h22, 8'h42);
    pulse_src(4, 0);
    wait_wake;
    chk(n >= RS + 5 && n <= RS + 9, 1);
    repeat (2) @(posedge sys_clk_i);
    #1 chk(bod, 1);
    $display("test detector done");
  endtask
  task t_restart;
    wreg(8'h21, 8'h20);
    do_sleep;
    pulse_src(7, 0);
    wait_wake;
    chk({wake_restart_o, sleeping_o, n[5:0]}, 8'h81);
    $display("test restart done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    @(posedge sys_clk_i) #1;
    t_reset;
    t_gate;
    t_idle;
    t_noise;
    t_down;
    t_refuse;
    t_bod;
    t_restart;
    test_done;
  end
endmodule // sleep_mode_power_controller_bench
